// *** rtl/spa_regs.vh ***
`ifndef SPA_REGS_VH
`define SPA_REGS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define SPA_CLK_NS      20
`define SPA_TICK_NS     100000000

// ****************************************************************
// Register offsets (byte addresses; setpoint blocks by ADDR[7:4], fields by ADDR[3:2])
// ****************************************************************
`define SPA_A_CTRL      8'h00
`define SPA_A_STAT      8'h04
`define SPA_A_SRST      8'h08
`define SPA_A_SP0       4'h1
`define SPA_A_SP1       4'h2
`define SPA_O_SETP      2'h0
`define SPA_O_HYST      2'h1
`define SPA_O_CFG       2'h2
`define SPA_O_DLY       2'h3

// ****************************************************************
// Control register fields
// ****************************************************************
`define SPA_C_SP2EN     0
`define SPA_C_GREEN     1
`define SPA_C_KEYDSP    2
`define SPA_C_USRDSP    3
`define SPA_C_UFN_LO    4
`define SPA_C_UFN_HI    6
`define SPA_C_KEYSEL_LO 7
`define SPA_C_KEYSEL_HI 8
`define SPA_CTRL_RST    9'h000

// ****************************************************************
// User input functions
// ****************************************************************
`define SPA_UFN_NONE    3'h0
`define SPA_UFN_SP1     3'h1
`define SPA_UFN_SP2     3'h2
`define SPA_UFN_BOTH    3'h3
`define SPA_UFN_DSP     3'h4

// ****************************************************************
// Setpoint config fields and encodings
// ****************************************************************
`define SPA_F_ACT_LO    0
`define SPA_F_ACT_HI    1
`define SPA_F_RM_LO     2
`define SPA_F_RM_HI     3
`define SPA_F_RWD       4
`define SPA_F_INH       5
`define SPA_F_CCH       6
`define SPA_CFG_RST     7'h00
`define SPA_ACT_HI_BAL  2'h0
`define SPA_ACT_LO_BAL  2'h1
`define SPA_ACT_HI_ONE  2'h2
`define SPA_ACT_LO_ONE  2'h3
`define SPA_RM_AUTO     2'h0
`define SPA_RM_INSTANT  2'h1
`define SPA_RM_DEFER    2'h2

// ****************************************************************
// Limits and reset values
// ****************************************************************
`define SPA_SP_MAX      32'sh0001869F
`define SPA_SP_MIN      (-32'sh00004E1F)
`define SPA_SP_RST      18'h00000
`define SPA_HYS_MAX     16'hEA5F
`define SPA_HYS_MIN     16'h0001
`define SPA_HYS_RST     16'h0001
`define SPA_DLY_MAX     16'hEA56
`define SPA_DLY_RST     32'h00000000

`endif

// *** rtl/spa_top.v ***
// Functional notes
// - Each output holds a signed setpoint up to 99999 compared to display.
// - Each output holds a hysteresis of 1 to 59999 display counts.
// - Action is high or low acting, with balanced or one-sided band.
// - One-sided band sits below setpoint when high, above when low.
// - Turn-on waits the on-delay, up to 5999 s; zero means no wait.
// - Turn-off waits the off-delay; zero means no added wait.
// - Automatic mode turns output off when value crosses off level.
// - Automatic mode: manual reset clears output until trigger recrossed.
// - Latch modes hold output on until key, user, serial reset or power.
// - Instant latch: manual reset clears output until trigger recrossed.
// - Deferred latch: reset waits pending until value crosses off level.
// - Pending deferred reset is lost at power-up unless request held.
// - Latched outputs are off at power-up below setpoint.
// - Display reset from key or user input may also reset output.
// - That combined reset needs display assignment and input shown.
// - Power-up inhibit keeps output off until off level first reached.
// - Colour change enabled toggles backlight on output state change.
// - Setpoints are inactive unless an output card is present.
// - Second output only runs when enabled and fitted on the card.
// - User input reset clears first, second or both outputs.
`timescale 1ns/1ps
`include "spa_regs.vh"

module spa_top #(
    parameter TICK_CYCLES = `SPA_TICK_NS / `SPA_CLK_NS
) (
    // Clock and reset
    input  wire        CLOCK,
    input  wire        RSTN,
    // Register port
    input  wire [7:0]  ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA,
    // Display value from the measurement path
    input  wire [17:0] DISPLAY_VALUE,
    input  wire        DISPLAY_VALID,
    input  wire        INPUT_SHOWN,
    // Pins
    input  wire        CARD_PRESENT,
    input  wire        CARD_DUAL,
    input  wire        BACKLIT,
    input  wire        RESET_KEY,
    input  wire        USER_INPUT,
    // Outputs
    output wire [1:0]  SP_OUT,
    output reg         BACKLIGHT_GREEN
);

    localparam [22:0] TICK_LAST = TICK_CYCLES[22:0] - 23'h000001;
    localparam [31:0] SPMAX     = `SPA_SP_MAX;
    localparam [31:0] SPMIN     = `SPA_SP_MIN;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function [17:0] clamp_sp;
        input [31:0] w;
        begin
            if ($signed(w) > $signed(SPMAX))
                clamp_sp = SPMAX[17:0];
            else if ($signed(w) < $signed(SPMIN))
                clamp_sp = SPMIN[17:0];
            else
                clamp_sp = w[17:0];
        end
    endfunction

    function [15:0] clamp_u;
        input [15:0] w;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (w > hi)
                clamp_u = hi;
            else if (w < lo)
                clamp_u = lo;
            else
                clamp_u = w;
        end
    endfunction

    // Trip test: value beyond setpoint shifted by an offset.
    function trip;
        input [17:0] v;
        input [17:0] s;
        input [16:0] off;
        input        above;
        reg signed [19:0] sv;
        reg signed [19:0] ss;
        reg signed [19:0] so;
        begin
            sv = {{2{v[17]}}, v};
            ss = {{2{s[17]}}, s};
            so = {3'h0, off};
            if (above)
                trip = sv >= ss + so;
            else
                trip = sv <= ss - so;
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers and edge detect
    // ****************************************************************
    reg [4:0] meta;
    reg [4:0] pins;
    reg       key_d;
    reg       usr_d;
    reg [1:0] init_cnt;

    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            meta     <= 5'h00;
            pins     <= 5'h00;
            key_d    <= 1'b0;
            usr_d    <= 1'b0;
            init_cnt <= 2'h3;
        end
        else
        begin
            meta  <= {USER_INPUT, RESET_KEY, BACKLIT, CARD_DUAL,
                      CARD_PRESENT};
            pins  <= meta;
            key_d <= pins[3];
            usr_d <= pins[4];
            if (init_cnt != 2'h0)
                init_cnt <= init_cnt - 2'h1;
        end
    end

    wire present = pins[0];
    wire dual    = pins[1];
    wire backlit = pins[2];
    wire key_ev  = pins[3] & ~key_d;
    wire usr_ev  = pins[4] & ~usr_d;
    // The sampled pins settle two edges after release; request levels
    // are caught in the first cycle after that window, at the third edge.
    wire init_pt = (init_cnt == 2'h1);

    // ****************************************************************
    // Tenth-second tick
    // ****************************************************************
    reg [22:0] tick_cnt;
    reg        tick;

    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            tick_cnt <= 23'h000000;
            tick     <= 1'b0;
        end
        else if (tick_cnt == TICK_LAST)
        begin
            tick_cnt <= 23'h000000;
            tick     <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 23'h000001;
            tick     <= 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [8:0]  ctrl;
    reg [17:0] setp [0:1];
    reg [15:0] hyst [0:1];
    reg [6:0]  cfg  [0:1];
    reg [31:0] dly  [0:1];
    reg [1:0]  srst;
    reg [17:0] disp;
    wire [1:0] pend;

    wire       sp_sel = (ADDR[7:4] == `SPA_A_SP0) |
                        (ADDR[7:4] == `SPA_A_SP1);
    wire       idx    = ADDR[5];
    wire [1:0] fld    = ADDR[3:2];
    integer    i;

    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ctrl  <= `SPA_CTRL_RST;
            srst  <= 2'h0;
            disp  <= 18'h00000;
            RDATA <= 32'h00000000;
            for (i = 0; i < 2; i = i + 1)
            begin
                setp[i] <= `SPA_SP_RST;
                hyst[i] <= `SPA_HYS_RST;
                cfg[i]  <= `SPA_CFG_RST;
                dly[i]  <= `SPA_DLY_RST;
            end
        end
        else
        begin
            srst <= 2'h0;
            if (DISPLAY_VALID)
                disp <= DISPLAY_VALUE;
            if (WR && ADDR == `SPA_A_CTRL)
                ctrl <= WDATA[8:0];
            if (WR && ADDR == `SPA_A_SRST)
                srst <= WDATA[1:0];
            if (WR && sp_sel && fld == `SPA_O_SETP)
                setp[idx] <= clamp_sp(WDATA);
            if (WR && sp_sel && fld == `SPA_O_HYST)
                hyst[idx] <= clamp_u(WDATA[15:0], `SPA_HYS_MIN,
                                     `SPA_HYS_MAX);
            if (WR && sp_sel && fld == `SPA_O_CFG)
                cfg[idx] <= WDATA[6:0];
            if (WR && sp_sel && fld == `SPA_O_DLY)
                dly[idx] <= {clamp_u(WDATA[31:16], 16'h0000,
                                     `SPA_DLY_MAX),
                             clamp_u(WDATA[15:0], 16'h0000,
                                     `SPA_DLY_MAX)};
            RDATA <= 32'h00000000;
            if (RD)
            begin
                if (ADDR == `SPA_A_CTRL)
                    RDATA <= {23'h000000, ctrl};
                else if (ADDR == `SPA_A_STAT)
                    RDATA <= {24'h000000, pend, BACKLIGHT_GREEN,
                              backlit, dual, present, SP_OUT};
                else if (sp_sel)
                    case (fld)
                        `SPA_O_SETP:
                            RDATA <= {{14{setp[idx][17]}}, setp[idx]};
                        `SPA_O_HYST: RDATA <= {16'h0000, hyst[idx]};
                        `SPA_O_CFG:  RDATA <= {25'h0000000, cfg[idx]};
                        default:     RDATA <= dly[idx];
                    endcase
            end
        end
    end

    // ****************************************************************
    // Reset sources
    // ****************************************************************
    wire [2:0] ufn = ctrl[`SPA_C_UFN_HI:`SPA_C_UFN_LO];
    wire [1:0] key_sel = ctrl[`SPA_C_KEYSEL_HI:`SPA_C_KEYSEL_LO];
    wire [1:0] usr_hit = {ufn == `SPA_UFN_SP2 || ufn == `SPA_UFN_BOTH,
                          ufn == `SPA_UFN_SP1 || ufn == `SPA_UFN_BOTH};
    wire dsp_rst = INPUT_SHOWN &
        ((key_ev & ctrl[`SPA_C_KEYDSP]) |
         (usr_ev & ctrl[`SPA_C_USRDSP] & ufn == `SPA_UFN_DSP));
    wire [1:0] active = {present & dual & ctrl[`SPA_C_SP2EN],
                         present};

    // ****************************************************************
    // Setpoint outputs
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : chan
            wire [6:0]  c    = cfg[g];
            wire [1:0]  act  = c[`SPA_F_ACT_HI:`SPA_F_ACT_LO];
            wire [1:0]  rm   = c[`SPA_F_RM_HI:`SPA_F_RM_LO];
            wire        low  = act[0];
            wire        bal  = ~act[1];
            wire [16:0] half = {2'h0, hyst[g][15:1]};
            // Balanced: both levels half a band from setpoint; one-sided:
            // on at setpoint, off a full band on the far side.
            wire [16:0] on_off  = bal ? half : 17'h00000;
            wire [16:0] off_off = bal ? half
                                      : {1'b0, hyst[g]};
            wire trig_on  = low ? trip(disp, setp[g], on_off, 1'b0)
                                : trip(disp, setp[g], on_off,
                                       1'b1);
            wire trig_off = low ? trip(disp, setp[g], off_off, 1'b1)
                                : trip(disp, setp[g], off_off, 1'b0);
            wire man = (key_ev & key_sel[g]) |
                       (usr_ev & usr_hit[g]) | srst[g] |
                       (dsp_rst & c[`SPA_F_RWD]);
            wire req = (pins[3] & key_sel[g]) | (pins[4] & usr_hit[g]);
            reg         out;
            reg         blk;
            reg         inh;
            reg         pnd;
            reg  [15:0] cnt;

            always @(posedge CLOCK or negedge RSTN)
            begin
                if (!RSTN)
                begin
                    out <= 1'b0;
                    blk <= 1'b0;
                    inh <= 1'b1;
                    pnd <= 1'b0;
                    cnt <= 16'h0000;
                end
                else if (!active[g])
                begin
                    out <= 1'b0;
                    blk <= 1'b0;
                    inh <= 1'b1;
                    pnd <= 1'b0;
                    cnt <= 16'h0000;
                end
                else
                begin
                    if (init_pt && req && rm == `SPA_RM_DEFER)
                        pnd <= 1'b1;
                    if (trig_off || !c[`SPA_F_INH])
                        inh <= 1'b0;
                    if (trig_off)
                        blk <= 1'b0;
                    if (man && out && rm == `SPA_RM_DEFER)
                        pnd <= 1'b1;
                    else if (man && out)
                    begin
                        out <= 1'b0;
                        blk <= 1'b1;
                        cnt <= 16'h0000;
                    end
                    else if (!out)
                    begin
                        if (trig_on && !blk && !inh)
                        begin
                            if (cnt >= dly[g][15:0])
                            begin
                                out <= 1'b1;
                                cnt <= 16'h0000;
                            end
                            else if (tick)
                                cnt <= cnt + 16'h0001;
                        end
                        else
                            cnt <= 16'h0000;
                    end
                    else if (trig_off &&
                             (rm == `SPA_RM_AUTO || pnd))
                    begin
                        if (cnt >= dly[g][31:16])
                        begin
                            out <= 1'b0;
                            pnd <= 1'b0;
                            cnt <= 16'h0000;
                        end
                        else if (tick)
                            cnt <= cnt + 16'h0001;
                    end
                    else
                        cnt <= 16'h0000;
                end
            end

            assign SP_OUT[g] = out;
            assign pend[g]   = pnd;
        end
    endgenerate

    // ****************************************************************
    // Backlight colour
    // ****************************************************************
    reg [1:0] out_d;
    reg       flip;
    wire [1:0] cch = {cfg[1][`SPA_F_CCH], cfg[0][`SPA_F_CCH]};

    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            out_d           <= 2'h0;
            flip            <= 1'b0;
            BACKLIGHT_GREEN <= 1'b0;
        end
        else
        begin
            out_d <= SP_OUT;
            if (backlit && |((SP_OUT ^ out_d) & cch))
                flip <= ~flip;
            BACKLIGHT_GREEN <= backlit & (ctrl[`SPA_C_GREEN] ^ flip);
        end
    end

endmodule

// *** bench/spa_card_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Output card: reports its fitting and takes the switch drive
// ****************************************************************
module spa_card_model (
    // Switch drive from the meter
    input  wire [1:0] sw_in,
    // Fitting chosen by the bench
    input  wire       fitted,
    input  wire       two_out,
    // Detection pins
    output wire       present,
    output wire       dual
);
    // A card that is pulled out takes its second channel with it.
    assign present = fitted;
    assign dual    = fitted & two_out;
endmodule

// *** bench/spa_checker_properties.sv ***
`timescale 1ns/1ps
module spa_checker #(
    parameter TICK_CYCLES = 10
) (
    // Clock and reset
    input wire        CLOCK,
    input wire        RSTN,
    // Register port
    input wire [7:0]  ADDR,
    input wire [31:0] WDATA,
    input wire        WR,
    input wire        RD,
    input wire [31:0] RDATA,
    // Pins and outputs
    input wire        CARD_PRESENT,
    input wire        CARD_DUAL,
    input wire        BACKLIT,
    input wire [1:0]  SP_OUT,
    input wire        BACKLIGHT_GREEN
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // ****************************************************************
    // Shadow state
    // ****************************************************************
    // The history lets colour moves be tied to a recent cause.
    reg       rm_def;
    reg       sp2en;
    reg [5:0] hist;
    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rm_def <= 1'b0;
            sp2en  <= 1'b0;
            hist   <= 6'h00;
        end
        else
        begin
            if (WR && ADDR == 8'h18)
                rm_def <= (WDATA[3:2] == 2'h2);
            if (WR && ADDR == 8'h00)
                sp2en <= WDATA[0];
            hist <= {hist[4:0], WR || (SP_OUT != $past(SP_OUT))
                     || (BACKLIT != $past(BACKLIT))};
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_rd_idle;
        !$past(RD) |-> RDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_stat;
        RD && ADDR == 8'h04 |=> RDATA[1:0] == $past(SP_OUT);
    endproperty
    a_stat: assert property (p_stat) else $error("status output mismatch");
    property p_release;
        $rose(RSTN) |-> SP_OUT == 2'h0 && RDATA == 32'h0;
    endproperty
    a_release: assert property (p_release)
        else $error("on after reset");
    property p_card;
        (!CARD_PRESENT) [*5] |-> SP_OUT == 2'h0;
    endproperty
    a_card: assert property (p_card)
        else $error("output without card");
    property p_dual;
        (!CARD_DUAL) [*5] |-> !SP_OUT[1];
    endproperty
    a_dual: assert property (p_dual)
        else $error("second on single card");
    property p_sp2en;
        !sp2en && !$past(sp2en) |-> !SP_OUT[1];
    endproperty
    a_sp2en: assert property (p_sp2en)
        else $error("second not enabled");
    property p_unlit;
        (!BACKLIT) [*5] |-> !BACKLIGHT_GREEN;
    endproperty
    a_unlit: assert property (p_unlit)
        else $error("colour on plain unit");
    property p_colour;
        $changed(BACKLIGHT_GREEN) |-> hist != 6'h00;
    endproperty
    a_colour: assert property (p_colour)
        else $error("colour moved alone");
    property p_serial;
        // The serial command is registered first, so the drop comes on
        // the second edge after the write.
        SP_OUT[0] && !rm_def && WR && ADDR == 8'h08 && WDATA[0]
            |-> ##2 !SP_OUT[0];
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial reset missed");
endmodule

bind spa_top spa_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .CLOCK          (CLOCK),
    .RSTN           (RSTN),
    .ADDR           (ADDR),
    .WDATA          (WDATA),
    .WR             (WR),
    .RD             (RD),
    .RDATA          (RDATA),
    .CARD_PRESENT   (CARD_PRESENT),
    .CARD_DUAL      (CARD_DUAL),
    .BACKLIT        (BACKLIT),
    .SP_OUT         (SP_OUT),
    .BACKLIGHT_GREEN(BACKLIGHT_GREEN)
);

// *** bench/test_setpoint_alarm_output.sv ***
`timescale 1ns/1ps
module test_setpoint_alarm_output;
    reg         CLOCK = 1'b0;
    reg         RSTN = 1'b0;
    reg  [7:0]  ADDR = 8'h00;
    reg  [31:0] WDATA = 32'h0;
    reg         WR = 1'b0;
    reg         RD = 1'b0;
    reg  [17:0] DISPLAY_VALUE = 18'h0;
    reg         DISPLAY_VALID = 1'b0;
    reg         INPUT_SHOWN = 1'b0;
    reg         BACKLIT = 1'b0;
    reg         RESET_KEY = 1'b0;
    reg         USER_INPUT = 1'b0;
    reg         fitted = 1'b1;
    reg         two_out = 1'b1;
    wire        CARD_PRESENT;
    wire        CARD_DUAL;
    wire [31:0] RDATA;
    wire [1:0]  SP_OUT;
    wire        BACKLIGHT_GREEN;
    wire [31:0] s0 = {31'h0, SP_OUT[0]};
    wire [31:0] s1 = {31'h0, SP_OUT[1]};
    wire [31:0] sg = {31'h0, BACKLIGHT_GREEN};
    reg  [37:0] tbl [0:3];
    reg  [31:0] rv;
    integer     mismatches = 0;
    integer     n_compared = 0;
    integer     i;
    integer     j;
    localparam [17:0] v_hi = 18'h0006E;
    localparam [17:0] v_lo = 18'h0005A;
    always #10 CLOCK = ~CLOCK;
    spa_top #(.TICK_CYCLES(10)) dut (
        .CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .DISPLAY_VALUE(DISPLAY_VALUE),
        .DISPLAY_VALID(DISPLAY_VALID), .INPUT_SHOWN(INPUT_SHOWN),
        .CARD_PRESENT(CARD_PRESENT), .CARD_DUAL(CARD_DUAL),
        .BACKLIT(BACKLIT), .RESET_KEY(RESET_KEY), .USER_INPUT(USER_INPUT),
        .SP_OUT(SP_OUT), .BACKLIGHT_GREEN(BACKLIGHT_GREEN));
    spa_card_model u_card (.sw_in(SP_OUT), .fitted(fitted),
        .two_out(two_out), .present(CARD_PRESENT), .dual(CARD_DUAL));
    // ****************************************************************
    // Bus and pin tasks
    // ****************************************************************
    task tick(input integer n);
        repeat (n) @(posedge CLOCK);
    endtask
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge CLOCK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    end
    endtask
    // Read data is only valid in the one cycle after the strobe.
    task rd(input [7:0] a, output [31:0] d);
    begin
        @(posedge CLOCK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 d = RDATA;
    end
    endtask
    task show(input [17:0] v);
    begin
        @(posedge CLOCK);
        DISPLAY_VALUE <= v;
        DISPLAY_VALID <= 1'b1;
        @(posedge CLOCK);
        DISPLAY_VALID <= 1'b0;
        tick(3);
    end
    endtask
    // Pins pass a synchroniser, so the pulse is held for several edges.
    task press(input key);
    begin
        @(posedge CLOCK);
        RESET_KEY  <= key;
        USER_INPUT <= !key;
        tick(3);
        RESET_KEY  <= 1'b0;
        USER_INPUT <= 1'b0;
        tick(4);
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task stop_test;
    begin
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    initial
    begin
        #200000;
        mismatches = mismatches + 1;
        stop_test;
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        // Each row: action, off / near-on / on / near-off values, outputs.
        tbl[0] = {2'h0, 32'h5F686960, 4'hC};
        tbl[1] = {2'h1, 32'h69605F68, 4'hC};
        tbl[2] = {2'h2, 32'h5A63645B, 4'hC};
        tbl[3] = {2'h3, 32'h6E65646D, 4'hC};
        tick(6);
        RSTN <= 1'b1;
        tick(2);
        wr(8'h10, 32'h00000064);
        wr(8'h14, 32'h0000000A);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h18, {30'h0, tbl[i][37:36]});
            for (j = 0; j < 4; j = j + 1)
            begin
                show({10'h000, tbl[i][35 - 8 * j -: 8]});
                check(s0, {31'h0, tbl[i][j]});
            end
        end
        show(v_hi);
        wr(8'h1C, 32'h00020003);
        wr(8'h18, 32'h0);
        show(v_hi);
        check(s0, 32'h0);
        tick(40);
        check(s0, 32'h1);
        show(v_lo);
        check(s0, 32'h1);
        tick(40);
        check(s0, 32'h0);
        wr(8'h1C, 32'h0);
        wr(8'h00, 32'h00000080);
        show(v_hi);
        press(1'b1);
        check(s0, 32'h0);
        show(18'h00070);
        check(s0, 32'h0);
        show(v_lo);
        show(v_hi);
        check(s0, 32'h1);
        show(v_lo);
        wr(8'h18, 32'h00000004);
        show(v_hi);
        show(v_lo);
        check(s0, 32'h1);
        wr(8'h08, 32'h00000001);
        tick(2);
        check(s0, 32'h0);
        show(v_hi);
        check(s0, 32'h1);
        wr(8'h00, 32'h00000010);
        press(1'b0);
        check(s0, 32'h0);
        show(18'h0006F);
        check(s0, 32'h0);
        show(v_lo);
        wr(8'h18, 32'h00000008);
        show(v_hi);
        press(1'b0);
        check(s0, 32'h1);
        rd(8'h04, rv);
        check({31'h0, rv[6]}, 32'h1);
        show(v_lo);
        check(s0, 32'h0);
        wr(8'h18, 32'h00000010);
        wr(8'h00, 32'h00000004);
        show(v_hi);
        press(1'b1);
        check(s0, 32'h1);
        INPUT_SHOWN <= 1'b1;
        press(1'b1);
        check(s0, 32'h0);
        show(v_lo);
        BACKLIT <= 1'b1;
        wr(8'h18, 32'h00000040);
        tick(4);
        check(sg, 32'h0);
        show(v_hi);
        tick(2);
        check(sg, 32'h1);
        show(v_lo);
        tick(2);
        check(sg, 32'h0);
        wr(8'h00, 32'h00000002);
        tick(2);
        check(sg, 32'h1);
        check(s1, 32'h0);
        wr(8'h00, 32'h00000001);
        tick(3);
        check(s1, 32'h1);
        wr(8'h00, 32'h00000021);
        press(1'b0);
        check(s1, 32'h0);
        show(18'h3FFFF);
        show(v_lo);
        check(s1, 32'h1);
        two_out <= 1'b0;
        tick(5);
        check(s1, 32'h0);
        show(v_hi);
        fitted <= 1'b0;
        tick(5);
        check({30'h0, SP_OUT}, 32'h0);
        wr(8'h10, 32'h000186A0);
        rd(8'h10, rv);
        check(rv, 32'h0001869F);
        wr(8'h14, 32'h0);
        rd(8'h14, rv);
        check(rv, 32'h00000001);
        rd(8'hF0, rv);
        check(rv, 32'h0);
        // Power-up with the key held: the deferred reset stays pending,
        // and the inhibited output waits until the off level is seen.
        tick(1);
        fitted    <= 1'b1;
        RESET_KEY <= 1'b1;
        RSTN      <= 1'b0;
        tick(6);
        RSTN          <= 1'b1;
        DISPLAY_VALUE <= v_hi;
        DISPLAY_VALID <= 1'b1;
        ADDR          <= 8'h18;
        WDATA         <= 32'h00000028;
        WR            <= 1'b1;
        tick(1);
        DISPLAY_VALID <= 1'b0;
        ADDR          <= 8'h00;
        WDATA         <= 32'h00000080;
        tick(1);
        WR        <= 1'b0;
        RESET_KEY <= 1'b0;
        tick(4);
        check(s0, 32'h0);
        rd(8'h04, rv);
        check({31'h0, rv[6]}, 32'h1);
        show(18'h3FFFF);
        check(s0, 32'h0);
        show(v_hi);
        check(s0, 32'h1);
        stop_test;
    end
endmodule
